// ===== core/power_state_consts.vh
`ifndef POWER_STATE_CONSTS_VH
`define POWER_STATE_CONSTS_VH

// ==========================================================================
// Timing
// ==========================================================================
// Clock period in nanoseconds.
`define CLK_PERIOD_NS     20
// Long-press threshold in milliseconds.
`define LONG_PRESS_MS     4000
// Long-press threshold in core clock cycles.
// Cycles per millisecond come first, so the product stays inside 32-bit integers.
`define LONG_PRESS_CYC    (`LONG_PRESS_MS * (1000000 / `CLK_PERIOD_NS))

// ==========================================================================
// Sleeping-state encodings of the OS command and state report
// ==========================================================================
`define ST_S0             3'h0
`define ST_S1             3'h1
`define ST_S3             3'h3
`define ST_S4             3'h4
`define ST_S5             3'h5

// ==========================================================================
// Wake source bit positions
// ==========================================================================
`define WK_MODEM          0
`define WK_PS2            1
`define WK_USB            2
`define WK_SWITCH         3
`define WK_RTC            4
`define WK_PCIE           5
`define WK_LAN            6
`define WK_PME            7
`define WK_COUNT          8

// ==========================================================================
// Monitoring
// ==========================================================================
`define RAIL_COUNT        5
`define FAN_COUNT         3

`endif

// ===== core/fan_loop.v
`timescale 1ns/1ps
`include "power_state_consts.vh"

// ==========================================================================
// One closed-loop fan channel
// ==========================================================================
module fan_loop #(
	parameter TW = 8
) (
	// Clock and reset.
	input  wire          core_clk,
	input  wire          reset,
	// Thermal input and control.
	input  wire [TW-1:0] temp,
	input  wire [TW-1:0] temp_low,
	input  wire [TW-1:0] temp_high,
	input  wire          fan_allow,
	// Fan drive.
	output reg  [TW-1:0] duty_ff,
	output reg           pwm_ff
);
	// Next duty value and free-running PWM ramp.
	reg  [TW-1:0] nxt_duty;
	reg  [TW-1:0] ramp_ff;

	// Duty follows temperature: off below the low mark, full above the high.
	always @*
	begin
		if (!fan_allow)
			nxt_duty = {TW{1'b0}};
		else if (temp <= temp_low)
			nxt_duty = {TW{1'b0}};
		else if (temp >= temp_high)
			nxt_duty = {TW{1'b1}};
		else if (temp > duty_ff)
			nxt_duty = duty_ff + 1'b1;
		else if (temp < duty_ff)
			nxt_duty = duty_ff - 1'b1;
		else
			nxt_duty = duty_ff;
	end

	// Registered duty, ramp and PWM; the duty steps by one per cycle between the marks and jumps to off or full at them.
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			duty_ff <= {TW{1'b0}};
			ramp_ff <= {TW{1'b0}};
			pwm_ff  <= 1'b0;
		end
		else
		begin
			duty_ff <= nxt_duty;
			ramp_ff <= ramp_ff + 1'b1;
			pwm_ff  <= (nxt_duty == {TW{1'b1}}) | (ramp_ff < nxt_duty);
		end
	end
endmodule // fan_loop

// ===== core/board_power_state_controller.v
// Notes on behaviour
// - Short press: off to on, on/sleep toggle.
// - Long press from on or sleep: off.
// - Other transitions only on OS command or wake.
// - Modem, PS/2, USB wake from S1, S3.
// - Switch, RTC, PCIe wake from all sleeps.
// - LAN, PME wake S5 only when enabled.
// - Closed intrusion switch reports intrusion.
// - Flag rails above or below limits.
// - Three fans under thermal closed loop.
// - OS may command soft-off from working.
// - Fans run only in S0 or S1.
`timescale 1ns/1ps
`include "power_state_consts.vh"

module board_power_state_controller #(
	parameter LONG_CYC = `LONG_PRESS_CYC,
	parameter VW       = 10,
	parameter TW       = 8
) (
	// Clock and reset.
	input  wire                  core_clk,
	input  wire                  reset,
	// Front panel and chassis pins, asynchronous.
	input  wire                  pwr_switch_n,
	input  wire                  intrusion_closed,
	// Wake requests, asynchronous.
	input  wire [`WK_COUNT-1:0]  wake_req,
	// Operating system command, same clock.
	input  wire                  os_cmd_valid,
	input  wire [2:0]            os_cmd_state,
	input  wire                  lan_s5_wake_en,
	// Rail readings and limits, packed per rail.
	input  wire [5*VW-1:0]       rail_value,
	input  wire [5*VW-1:0]       rail_high,
	input  wire [5*VW-1:0]       rail_low,
	// Thermal inputs for the fans.
	input  wire [3*TW-1:0]       fan_temp,
	input  wire [TW-1:0]         temp_low,
	input  wire [TW-1:0]         temp_high,
	// Status outputs.
	output reg  [2:0]            state_ff,
	output reg                   main_power_ff,
	output reg                   intrusion_ff,
	output reg  [4:0]            rail_fault_ff,
	output reg  [2:0]            fan_pwm_ff
);
	// ======================================================================
	// Input synchronisers
	// ======================================================================
	// Three stages; the change counts once stages two and three agree.
	reg  [2:0] sw_sync_ff;
	reg  [2:0] in_sync_ff;
	reg  [3*`WK_COUNT-1:0] wk_sync_ff;
	reg        sw_ff;                // Filtered press level, high while held.
	reg        in_ff;                // Filtered intrusion level.
	reg  [`WK_COUNT-1:0] wk_ff;      // Filtered wake levels.
	reg  [`WK_COUNT-1:0] wk_prev_ff; // For rising-edge detect.

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			sw_sync_ff <= 3'h0;
			in_sync_ff <= 3'h0;
			wk_sync_ff <= {3*`WK_COUNT{1'b0}};
			sw_ff      <= 1'b0;
			in_ff      <= 1'b0;
			wk_ff      <= {`WK_COUNT{1'b0}};
			wk_prev_ff <= {`WK_COUNT{1'b0}};
		end
		else
		begin
			sw_sync_ff <= {sw_sync_ff[1:0], ~pwr_switch_n};
			in_sync_ff <= {in_sync_ff[1:0], intrusion_closed};
			wk_sync_ff <= {wk_sync_ff[2*`WK_COUNT-1:0], wake_req};
			if (sw_sync_ff[1] == sw_sync_ff[2])
				sw_ff <= sw_sync_ff[2];
			if (in_sync_ff[1] == in_sync_ff[2])
				in_ff <= in_sync_ff[2];
			wk_ff      <= (wk_sync_ff[2*`WK_COUNT-1:`WK_COUNT]
				& wk_sync_ff[3*`WK_COUNT-1:2*`WK_COUNT])
				| (wk_ff & (wk_sync_ff[2*`WK_COUNT-1:`WK_COUNT]
				| wk_sync_ff[3*`WK_COUNT-1:2*`WK_COUNT]));
			wk_prev_ff <= wk_ff;
		end
	end

	// ======================================================================
	// Press timer
	// ======================================================================
	// Counter saturates at the threshold so a held switch fires only once.
	reg  [31:0] press_cnt_ff;
	reg         sw_prev_ff;
	wire        long_hit  = sw_ff && (press_cnt_ff == LONG_CYC - 1);
	wire        short_rel = !sw_ff && sw_prev_ff
		&& (press_cnt_ff < LONG_CYC);

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			press_cnt_ff <= 32'h0000_0000;
			sw_prev_ff   <= 1'b0;
		end
		else
		begin
			sw_prev_ff <= sw_ff;
			if (!sw_ff && !sw_prev_ff)
				press_cnt_ff <= 32'h0000_0000;
			else if (sw_ff && press_cnt_ff < LONG_CYC)
				press_cnt_ff <= press_cnt_ff + 32'h0000_0001;
		end
	end

	// ======================================================================
	// Wake qualification
	// ======================================================================
	// Decides whether any new wake edge may wake from a given sleep state.
	function wake_ok;
		input [2:0]           st;
		input [`WK_COUNT-1:0] ev;
		input                 lan_en;
		reg                   light;
		begin
			light   = (st == `ST_S1) || (st == `ST_S3);
			wake_ok = (light && (ev[`WK_MODEM] || ev[`WK_PS2]
				|| ev[`WK_USB]))
				|| ((light || st == `ST_S4 || st == `ST_S5)
				&& (ev[`WK_SWITCH] || ev[`WK_RTC] || ev[`WK_PCIE]))
				|| ((light || st == `ST_S4 || (st == `ST_S5 && lan_en))
				&& (ev[`WK_LAN] || ev[`WK_PME]));
		end
	endfunction

	wire [`WK_COUNT-1:0] wk_rise = wk_ff & ~wk_prev_ff;

	// ======================================================================
	// Power state machine
	// ======================================================================
	// One-hot phases: on (S0), asleep (S1/S3/S4), off (S5).
	localparam PH_ON    = 3'b001;
	localparam PH_SLEEP = 3'b010;
	localparam PH_OFF   = 3'b100;

	reg  [2:0] phase_ff;
	reg  [2:0] nxt_phase;
	reg  [2:0] nxt_state;

	always @*
	begin
		nxt_phase = phase_ff;
		nxt_state = state_ff;
		case (phase_ff)
			PH_ON:
			begin
				if (long_hit)
				begin
					nxt_phase = PH_OFF;
					nxt_state = `ST_S5;
				end
				else if (short_rel)
				begin
					nxt_phase = PH_SLEEP;
					nxt_state = `ST_S1;
				end
				else if (os_cmd_valid && os_cmd_state == `ST_S5)
				begin
					nxt_phase = PH_OFF;
					nxt_state = `ST_S5;
				end
				else if (os_cmd_valid && (os_cmd_state == `ST_S1
					|| os_cmd_state == `ST_S3 || os_cmd_state == `ST_S4))
				begin
					nxt_phase = PH_SLEEP;
					nxt_state = os_cmd_state;
				end
			end
			PH_SLEEP:
			begin
				if (long_hit)
				begin
					nxt_phase = PH_OFF;
					nxt_state = `ST_S5;
				end
				else if (short_rel || wake_ok(state_ff, wk_rise, lan_s5_wake_en))
				begin
					nxt_phase = PH_ON;
					nxt_state = `ST_S0;
				end
			end
			PH_OFF:
			begin
				// A release after a long press that forced off is ignored.
				if (short_rel || wake_ok(state_ff, wk_rise, lan_s5_wake_en))
				begin
					nxt_phase = PH_ON;
					nxt_state = `ST_S0;
				end
			end
			default:
			begin
				nxt_phase = PH_OFF;
				nxt_state = `ST_S5;
			end
		endcase
	end

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			phase_ff      <= PH_OFF;
			state_ff      <= `ST_S5;
			main_power_ff <= 1'b0;
		end
		else
		begin
			phase_ff      <= nxt_phase;
			state_ff      <= nxt_state;
			main_power_ff <= (nxt_state == `ST_S0) || (nxt_state == `ST_S1);
		end
	end

	// ======================================================================
	// Intrusion and rail monitoring
	// ======================================================================
	reg  [4:0] nxt_fault;
	integer    i;

	// Each rail is compared against its own window.
	always @*
	begin
		nxt_fault = 5'h0;
		for (i = 0; i < `RAIL_COUNT; i = i + 1)
			nxt_fault[i] = (rail_value[i*VW +: VW] > rail_high[i*VW +: VW])
				|| (rail_value[i*VW +: VW] < rail_low[i*VW +: VW]);
	end

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			intrusion_ff  <= 1'b0;
			rail_fault_ff <= 5'h0;
		end
		else
		begin
			intrusion_ff  <= in_ff;
			rail_fault_ff <= nxt_fault;
		end
	end

	// ======================================================================
	// Fan channels
	// ======================================================================
	wire       fan_allow = (state_ff == `ST_S0) || (state_ff == `ST_S1);
	wire [2:0] fan_pwm;

	genvar g;
	generate
		for (g = 0; g < `FAN_COUNT; g = g + 1)
		begin : fans
			fan_loop #(
				.TW (TW)
			) u_fan (
				.core_clk  (core_clk),
				.reset     (reset),
				.temp      (fan_temp[g*TW +: TW]),
				.temp_low  (temp_low),
				.temp_high (temp_high),
				.fan_allow (fan_allow),
				.duty_ff   (),
				.pwm_ff    (fan_pwm[g])
			);
		end
	endgenerate

	// Retime so the port comes straight from a flip-flop.
	always @(posedge core_clk)
	begin
		if (reset)
			fan_pwm_ff <= 3'h0;
		else
			fan_pwm_ff <= fan_pwm & {3{fan_allow}};
	end
endmodule // board_power_state_controller

// ===== dv/board_power_state_checker.sv
`timescale 1ns/1ps
`include "power_state_consts.vh"
// ==========================================
// Port-level checker for the power controller
// ==========================================
module board_power_state_checker #(
	parameter LONG_CYC = 50,
	parameter VW       = 10
) (
	// Clock and reset.
	input logic                 core_clk,
	input logic                 reset,
	// Pins and commands.
	input logic                 pwr_switch_n,
	input logic                 intrusion_closed,
	input logic [`WK_COUNT-1:0] wake_req,
	input logic                 os_cmd_valid,
	input logic [2:0]           os_cmd_state,
	input logic [5*VW-1:0]      rail_value,
	input logic [5*VW-1:0]      rail_high,
	input logic [5*VW-1:0]      rail_low,
	// Status.
	input logic [2:0]           state_ff,
	input logic                 main_power_ff,
	input logic                 intrusion_ff,
	input logic [4:0]           rail_fault_ff,
	input logic [2:0]           fan_pwm_ff
);
	logic [3:0]  quiet_ff; // Cycles with no press and no wake level, saturating.
	logic [31:0] held_ff;  // Length of the press now in progress.
	logic [4:0]  win;      // Rails outside their window right now.
	logic        run;      // Board is in a running state.
	// Quiet time lets the input synchronisers drain before a hold is demanded.
	always_ff @(posedge core_clk)
	begin
		if (reset || !pwr_switch_n || wake_req != 0)
			quiet_ff <= 4'h0;
		else if (quiet_ff != 4'hf)
			quiet_ff <= quiet_ff + 4'h1;
		held_ff <= (reset || pwr_switch_n) ? 32'h0 : held_ff + 32'h1;
	end
	// Window compare per rail; equal to a limit is still in range.
	always_comb
		for (int i = 0; i < 5; i++)
			win[i] = rail_value[i*VW+:VW] > rail_high[i*VW+:VW]
				|| rail_value[i*VW+:VW] < rail_low[i*VW+:VW];
	assign run = state_ff == `ST_S0 || state_ff == `ST_S1;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// A tap of exactly eight cycles from the off state.
	sequence s_idle_off;
		state_ff == `ST_S5 && quiet_ff == 4'hf && pwr_switch_n;
	endsequence
	sequence s_tap;
		!pwr_switch_n [*8] ##1 pwr_switch_n;
	endsequence
	a_short_press_on: assert property (
		s_idle_off ##1 s_tap |-> ##[1:12] state_ff == `ST_S0)
		else $error("short press did not power on");
	a_long_press_off: assert property (
		held_ff == LONG_CYC + 4 |=> state_ff == `ST_S5)
		else $error("long press did not force off");
	a_os_cmd_taken: assert property (
		os_cmd_valid && state_ff == `ST_S0 && quiet_ff == 4'hf
		&& os_cmd_state inside {`ST_S1, `ST_S3, `ST_S4, `ST_S5}
		|=> state_ff == $past(os_cmd_state))
		else $error("os command not taken");
	a_os_cmd_refused: assert property (
		os_cmd_valid && state_ff != `ST_S0 && quiet_ff == 4'hf |=> $stable(state_ff))
		else $error("os command taken while asleep");
	a_no_cause_hold: assert property (
		quiet_ff == 4'hf && !os_cmd_valid |=> $stable(state_ff))
		else $error("state moved without cause");
	a_power_follows: assert property (
		main_power_ff == run)
		else $error("main power disagrees with state");
	a_fans_off_asleep: assert property (
		!run [*3] |-> fan_pwm_ff == 3'h0)
		else $error("fan driven while asleep");
	a_intrusion_set: assert property (
		intrusion_closed [*6] |-> intrusion_ff)
		else $error("intrusion not reported");
	a_intrusion_clear: assert property (
		!intrusion_closed [*6] |-> !intrusion_ff)
		else $error("intrusion reported with cover on");
	a_rail_window: assert property (
		!$past(reset) |-> rail_fault_ff == $past(win))
		else $error("rail fault flags wrong");
endmodule // board_power_state_checker

bind board_power_state_controller board_power_state_checker #(
	.LONG_CYC(LONG_CYC), .VW(VW)) board_power_state_checker_inst (
	.core_clk(core_clk), .reset(reset), .pwr_switch_n(pwr_switch_n),
	.intrusion_closed(intrusion_closed), .wake_req(wake_req),
	.os_cmd_valid(os_cmd_valid), .os_cmd_state(os_cmd_state),
	.rail_value(rail_value), .rail_high(rail_high), .rail_low(rail_low),
	.state_ff(state_ff), .main_power_ff(main_power_ff), .intrusion_ff(intrusion_ff),
	.rail_fault_ff(rail_fault_ff), .fan_pwm_ff(fan_pwm_ff));

// ===== dv/front_panel_model.sv
`timescale 1ns/1ps
`include "power_state_consts.vh"
// ==========================================
// Front panel switch and wake sources
// ==========================================
module front_panel_model (
	// Clock.
	input  logic                 core_clk,
	// Pins toward the board.
	output logic                 pwr_switch_n,
	output logic [`WK_COUNT-1:0] wake_req
);
	initial
	begin
		pwr_switch_n = 1'b1;
		wake_req = '0;
	end
	// Hold the switch for n sampled cycles; called just after a rising edge.
	task automatic press(input int n);
		pwr_switch_n <= 1'b0;
		repeat (n) @(posedge core_clk);
		pwr_switch_n <= 1'b1;
	endtask
	// Wake sources give a level, so a short pulse could be lost in the sync.
	task automatic wake(input int b);
		wake_req[b] <= 1'b1;
		repeat (6) @(posedge core_clk);
		wake_req[b] <= 1'b0;
	endtask
endmodule // front_panel_model

// ===== dv/board_power_state_controller_tb_top.sv
`timescale 1ns/1ps
`include "power_state_consts.vh"
`define CHK(nm, e, g) \
	begin \
		checked++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("BAD %s exp %0h got %0h", nm, e, g); \
		end \
	end
// ==========================================
// Self-checking bench
// ==========================================
module board_power_state_controller_tb_top;
	localparam LC = 50; // Short threshold keeps the long-press runs brief.
	logic        core_clk = 0, reset = 1, intrusion_closed = 0;
	logic        os_cmd_valid = 0, lan_s5_wake_en = 0, pwr_switch_n;
	logic [2:0]  os_cmd_state = 0, state_ff, fan_pwm_ff, st;
	logic [7:0]  wake_req;
	logic [49:0] rail_value = {5{10'h100}}, rail_high = {5{10'h200}}, rail_low = {5{10'h080}};
	logic [23:0] fan_temp = {3{8'h10}};
	logic [7:0]  temp_low = 8'h20, temp_high = 8'h60;
	logic        main_power_ff, intrusion_ff, ok;
	logic [4:0]  rail_fault_ff;
	logic [2:0]  sl [4] = '{3'h1, 3'h3, 3'h4, 3'h5};
	int          checked = 0, bad_count = 0, fc [3];
	board_power_state_controller #(.LONG_CYC(LC)) board_power_state_controller_inst (
		.core_clk(core_clk), .reset(reset), .pwr_switch_n(pwr_switch_n),
		.intrusion_closed(intrusion_closed), .wake_req(wake_req),
		.os_cmd_valid(os_cmd_valid), .os_cmd_state(os_cmd_state),
		.lan_s5_wake_en(lan_s5_wake_en), .rail_value(rail_value), .rail_high(rail_high),
		.rail_low(rail_low), .fan_temp(fan_temp), .temp_low(temp_low),
		.temp_high(temp_high), .state_ff(state_ff), .main_power_ff(main_power_ff),
		.intrusion_ff(intrusion_ff), .rail_fault_ff(rail_fault_ff), .fan_pwm_ff(fan_pwm_ff));
	front_panel_model front_panel_model_inst (.core_clk(core_clk),
		.pwr_switch_n(pwr_switch_n), .wake_req(wake_req));
	initial
		forever #10 core_clk = ~core_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic push(input int n);
		front_panel_model_inst.press(n);
	endtask
	task automatic cmd(input logic [2:0] s);
		os_cmd_valid <= 1'b1;
		os_cmd_state <= s;
		tick(1);
		os_cmd_valid <= 1'b0;
		tick(20);
	endtask
	// Wait bounded for a state, then let it settle so a late wrong move shows.
	task automatic exp_st(input logic [2:0] e);
		int i;
		for (i = 0; i < 30 && state_ff !== e; i++)
			tick(1);
		tick(20);
		`CHK("state", e, state_ff)
		if (i == 30)
		begin
			bad_count++;
			stop_test();
		end
	endtask
	task automatic stop_test();
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog against a hang anywhere in the sequence.
	initial
	begin
		tick(100000);
		bad_count++;
		stop_test();
	end
	initial
	begin
		tick(4);
		reset <= 1'b0;
		tick(1);
		`CHK("reset state", `ST_S5, state_ff)
		`CHK("reset power", 1'b0, main_power_ff)
		$display("test reset done");
		push(8);
		exp_st(`ST_S0);
		`CHK("power on", 1'b1, main_power_ff)
		push(8);
		exp_st(`ST_S1);
		push(LC - 1);
		exp_st(`ST_S0);
		push(LC);
		exp_st(`ST_S5);
		push(8);
		exp_st(`ST_S0);
		cmd(`ST_S3);
		exp_st(`ST_S3);
		cmd(`ST_S0);
		exp_st(`ST_S3);
		push(LC + 5);
		exp_st(`ST_S5);
		push(8);
		exp_st(`ST_S0);
		front_panel_model_inst.wake(4);
		exp_st(`ST_S0);
		cmd(`ST_S5);
		exp_st(`ST_S5);
		push(8);
		exp_st(`ST_S0);
		$display("test switch and commands done");
		// Every wake source from every sleeping state, with and without the enable.
		for (int en = 0; en < 2; en++)
			for (int k = 0; k < 4; k++)
				for (int b = 0; b < 8; b++)
				begin
					lan_s5_wake_en <= en[0];
					st = sl[k];
					ok = st < 3'h4 || (b > 2 && (b < 6 || st != `ST_S5 || en == 1));
					cmd(st);
					front_panel_model_inst.wake(b);
					exp_st(ok ? `ST_S0 : st);
					if (state_ff !== `ST_S0)
					begin
						push(8);
						exp_st(`ST_S0);
					end
				end
		$display("test wake table done");
		fan_temp <= {8'h60, 8'h40, 8'h70};
		tick(300);
		fc = '{0, 0, 0};
		repeat (256)
		begin
			tick(1);
			for (int f = 0; f < 3; f++)
				fc[f] += fan_pwm_ff[f];
		end
		`CHK("fan duty", 3'h5, {fc[2] > 250, fc[1] > 250, fc[0] > 250})
		`CHK("fan mid", 64, fc[1])
		cmd(`ST_S3);
		tick(10);
		`CHK("fan off", 3'h0, fan_pwm_ff)
		$display("test fans done");
		intrusion_closed <= 1'b1;
		tick(10);
		`CHK("intrusion", 1'b1, intrusion_ff)
		intrusion_closed <= 1'b0;
		tick(10);
		`CHK("intrusion", 1'b0, intrusion_ff)
		rail_value <= {10'h07f, 10'h100, 10'h201, 10'h080, 10'h200};
		tick(3);
		`CHK("rails", 5'h14, rail_fault_ff)
		$display("test monitors done");
		stop_test();
	end
endmodule // board_power_state_controller_tb_top
